// ==== fsg_pkg.sv ====
// Package of constants for the fault status and pin I/O register bank
package fsg_pkg;
	localparam int          CHANS          = 8;
	localparam int          PINS           = 4;
	localparam int          ADDR_W         = 5;
	localparam int          CODE_W         = 3;
	localparam int          LVL_W          = 10;
	localparam logic [4:0]  ADDR_POS_FAULT = 5'h12;
	localparam logic [4:0]  ADDR_NEG_FAULT = 5'h13;
	localparam logic [4:0]  ADDR_PIN       = 5'h14;
	localparam int          PIN_DATA_LSB   = 4;
	localparam int          PIN_DIR_LSB    = 0;
	localparam logic [3:0]  DIR_RESET      = 4'hf;
	localparam logic [3:0]  DATA_RESET     = 4'h0;
	localparam logic [7:0]  FAULT_RESET    = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
	// Trip levels in tenths of a percent of the supply span
	localparam logic [9:0]  SPAN_FULL      = 10'h3e8;
	localparam logic [9:0]  HI_LVL_0       = 10'h3b6;
	localparam logic [9:0]  HI_LVL_1       = 10'h39d;
	localparam logic [9:0]  HI_LVL_2       = 10'h384;
	localparam logic [9:0]  HI_LVL_3       = 10'h36b;
	localparam logic [9:0]  HI_LVL_4       = 10'h352;
	localparam logic [9:0]  HI_LVL_5       = 10'h320;
	localparam logic [9:0]  HI_LVL_6       = 10'h2ee;
	localparam logic [9:0]  HI_LVL_7       = 10'h2bc;
	localparam logic [2:0]  CODE_RESET     = 3'h0;
endpackage : fsg_pkg

// ==== fsg_trip_cmp.sv ====
// One channel input pair compared with the shared trip levels
`timescale 1ns/10ps
module fsg_trip_cmp (
	input  wire logic [9:0] pos_level_in,
	input  wire logic [9:0] neg_level_in,
	input  wire logic [9:0] hi_level_in,
	input  wire logic [9:0] lo_level_in,
	output logic            pos_trip_out,
	output logic            neg_trip_out
);
	// Beyond either level is a fault; equality does not trip
	assign pos_trip_out = (pos_level_in > hi_level_in) |
		(pos_level_in < lo_level_in);
	assign neg_trip_out = (neg_level_in > hi_level_in) |
		(neg_level_in < lo_level_in);
endmodule : fsg_trip_cmp

// ==== fsg_regs.sv ====
`timescale 1ns/10ps
module fsg_regs (
	input  wire logic                         clock_in,
	input  wire logic                         rst_b_in,
	input  wire logic                         clk_en_in,
	input  wire logic [fsg_pkg::ADDR_W-1:0]   reg_addr_in,
	input  wire logic                         reg_wr_in,
	input  wire logic                         reg_rd_in,
	input  wire logic [7:0]                   reg_wdata_in,
	output logic      [7:0]                   reg_rdata_out,
	input  wire logic [fsg_pkg::CODE_W-1:0]   trip_level_code_in,
	input  wire logic [fsg_pkg::CHANS*10-1:0] positive_input_in,
	input  wire logic [fsg_pkg::CHANS*10-1:0] negative_input_in,
	output logic      [7:0]                   stream_pos_status_out,
	output logic      [7:0]                   stream_neg_status_out,
	input  wire logic [fsg_pkg::PINS-1:0]     pin_in,
	output logic      [fsg_pkg::PINS-1:0]     pin_out,
	output logic      [fsg_pkg::PINS-1:0]     pin_oe_out
);
	logic [fsg_pkg::CHANS-1:0] chan_pos_trip;
	logic [fsg_pkg::CHANS-1:0] chan_neg_trip;
	logic [7:0]                pos_fault_status_r;
	logic [7:0]                neg_fault_status_r;
	logic [3:0]                pin_direction_bits_r;
	logic [3:0]                pin_out_level_r;
	logic [3:0]                pin_meta_r;
	logic [3:0]                pin_sync_r;
	logic [2:0]                code_r;
	logic [7:0]                rdata_r;
	logic [7:0]                rdata_nxt;
	logic [9:0]                hi_level;
	logic [9:0]                lo_level;
	logic [3:0]                pin_data_bits;
	logic                      wr_pin;
	logic                      wr_take;
	logic [3:0]                wr_data;
	logic [3:0]                wr_dir;

	// Decode of code to high-side level, shared by every channel
	function automatic logic [9:0] hi_of(input logic [2:0] c);
		unique case (c)
			3'h0: hi_of = fsg_pkg::HI_LVL_0;
			3'h1: hi_of = fsg_pkg::HI_LVL_1;
			3'h2: hi_of = fsg_pkg::HI_LVL_2;
			3'h3: hi_of = fsg_pkg::HI_LVL_3;
			3'h4: hi_of = fsg_pkg::HI_LVL_4;
			3'h5: hi_of = fsg_pkg::HI_LVL_5;
			3'h6: hi_of = fsg_pkg::HI_LVL_6;
			3'h7: hi_of = fsg_pkg::HI_LVL_7;
		endcase
	endfunction : hi_of

	// Code is registered so a change lands on all channels in one edge
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			code_r <= fsg_pkg::CODE_RESET;
		end else if (clk_en_in) begin
			code_r <= trip_level_code_in;
		end
	end

	// Low side mirrors the high side about mid span
	assign hi_level = hi_of(code_r);
	assign lo_level = fsg_pkg::SPAN_FULL - hi_level;

	genvar g;
	generate
		for (g = 0; g < fsg_pkg::CHANS; g++) begin : g_chan
			fsg_trip_cmp u_cmp (
				.pos_level_in (positive_input_in[g*fsg_pkg::LVL_W +:
					fsg_pkg::LVL_W]),
				.neg_level_in (negative_input_in[g*fsg_pkg::LVL_W +:
					fsg_pkg::LVL_W]),
				.hi_level_in  (hi_level),
				.lo_level_in  (lo_level),
				.pos_trip_out (chan_pos_trip[g]),
				.neg_trip_out (chan_neg_trip[g])
			);
		end
	endgenerate

	// Status shows the live comparator state sampled every cycle that clk_en_in is high
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pos_fault_status_r <= fsg_pkg::FAULT_RESET;
			neg_fault_status_r <= fsg_pkg::FAULT_RESET;
		end else if (clk_en_in) begin
			pos_fault_status_r <= chan_pos_trip;
			neg_fault_status_r <= chan_neg_trip;
		end
	end

	// Sense enables live elsewhere; the host masks these bytes itself
	assign stream_pos_status_out = pos_fault_status_r;
	assign stream_neg_status_out = neg_fault_status_r;

	// Pins come from outside the clock domain
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_meta_r <= fsg_pkg::DATA_RESET;
			pin_sync_r <= fsg_pkg::DATA_RESET;
		end else if (clk_en_in) begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// Address compare shared by the write strobe and the read selects
	function automatic logic addr_hit(
		input logic [fsg_pkg::ADDR_W-1:0] addr,
		input logic [fsg_pkg::ADDR_W-1:0] target
	);
		addr_hit = (addr == target);
	endfunction : addr_hit

	assign wr_pin  = reg_wr_in & addr_hit(reg_addr_in, fsg_pkg::ADDR_PIN);
	assign wr_take = clk_en_in & wr_pin;
	assign wr_data = reg_wdata_in[fsg_pkg::PIN_DATA_LSB +: fsg_pkg::PINS];
	assign wr_dir  = reg_wdata_in[fsg_pkg::PIN_DIR_LSB +: fsg_pkg::PINS];

	// Direction and data land together: a pin turned to output by a write
	// drives the data bit of that same byte, so one write is enough
	genvar p;
	generate
		for (p = 0; p < fsg_pkg::PINS; p++) begin : g_pin
			always_ff @(posedge clock_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					pin_direction_bits_r[p] <= fsg_pkg::DIR_RESET[p];
				end else if (wr_take) begin
					pin_direction_bits_r[p] <= wr_dir[p];
				end
			end

			// Input pins keep their latch; a later turn-round to output drives
			// the data bit of the write that turns the pin round
			always_ff @(posedge clock_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					pin_out_level_r[p] <= fsg_pkg::DATA_RESET[p];
				end else if (wr_take && !wr_dir[p]) begin
					pin_out_level_r[p] <= wr_data[p];
				end
			end

			assign pin_out[p]    = pin_out_level_r[p];
			assign pin_oe_out[p] = ~pin_direction_bits_r[p];
		end
	endgenerate

	assign pin_data_bits = pin_sync_r;

	// Unmapped addresses read as zero rather than aliasing a register
	always_comb begin
		rdata_nxt = fsg_pkg::UNMAPPED_READ;
		if (addr_hit(reg_addr_in, fsg_pkg::ADDR_POS_FAULT)) begin
			rdata_nxt = pos_fault_status_r;
		end else if (addr_hit(reg_addr_in, fsg_pkg::ADDR_NEG_FAULT)) begin
			rdata_nxt = neg_fault_status_r;
		end else if (addr_hit(reg_addr_in, fsg_pkg::ADDR_PIN)) begin
			rdata_nxt = {pin_data_bits, pin_direction_bits_r};
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_r <= fsg_pkg::UNMAPPED_READ;
		end else if (clk_en_in && reg_rd_in) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;
endmodule : fsg_regs

// ==== fsg_regs_asserts.sv ====
// Checker for the fault status and pin register bank
`timescale 1ns/10ps
module fsg_regs_asserts (
	input wire logic       clock_in,
	input wire logic       rst_b_in,
	input wire logic       clk_en_in,
	input wire logic [4:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [7:0] stream_pos_status_out,
	input wire logic [7:0] stream_neg_status_out,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe_out
);
	wire       rd = reg_rd_in && clk_en_in;
	wire       wr = reg_wr_in && clk_en_in && reg_addr_in == 5'h14;
	wire [4:0] a  = reg_addr_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	pos_read_a: assert property (rd && a == 5'h12 |=>
		reg_rdata_out == $past(stream_pos_status_out)) else $error("pos read");
	neg_read_a: assert property (rd && a == 5'h13 |=>
		reg_rdata_out == $past(stream_neg_status_out)) else $error("neg read");
	dir_read_a: assert property (rd && a == 5'h14 |=>
		reg_rdata_out[3:0] == ~$past(pin_oe_out)) else $error("dir read");
	dir_write_a: assert property (wr |=>
		pin_oe_out == ~$past(reg_wdata_in[3:0])) else $error("dir write");
	out_write_a: assert property (wr && reg_wdata_in[3:0] == 4'h0 |=>
		pin_out == $past(reg_wdata_in[7:4])) else $error("pin drive");
	in_hold_a: assert property (wr |=>
		((pin_out ^ $past(pin_out)) & $past(reg_wdata_in[3:0])) == 4'h0)
		else $error("input pin moved");
	out_hold_a: assert property (!wr |=>
		$stable(pin_out) && $stable(pin_oe_out)) else $error("pin moved");
	bad_addr_a: assert property (rd && !(a inside {5'h12, 5'h13, 5'h14})
		|=> reg_rdata_out == 8'h00) else $error("unmapped read");
	rd_hold_a: assert property (!rd |=>
		$stable(reg_rdata_out)) else $error("read data moved");
	cover property (rd && a == 5'h12);
	cover property (wr && reg_wdata_in[3:0] == 4'h0);
	cover property (!clk_en_in);
	cover property (wr && reg_wdata_in[3:0] != 4'h0);
endmodule : fsg_regs_asserts
bind fsg_regs fsg_regs_asserts u_chk (.clock_in, .rst_b_in, .clk_en_in,
	.reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
	.stream_pos_status_out, .stream_neg_status_out, .pin_out, .pin_oe_out);

// ==== fsg_pin_model.sv ====
// Board side of the four pins
`timescale 1ns/10ps
module fsg_pin_model (
	input  wire logic [3:0] drive_in,
	input  wire logic [3:0] oe_in,
	input  wire logic [3:0] ext_in,
	output logic      [3:0] level_out
);
	// Undriven pins follow the outside level, as a pull would
	assign level_out = (drive_in & oe_in) | (ext_in & ~oe_in);
endmodule : fsg_pin_model

// ==== fsg_regs_tb_top.sv ====
// Self-checking bench for the fault status and pin register bank
`timescale 1ns/10ps
module fsg_regs_tb_top;
	logic        clock_in, rst_b_in, clk_en_in, wr, rd;
	logic [4:0]  addr;
	logic [7:0]  wdata, rdata, spos, sneg, sense_en;
	logic [2:0]  code;
	logic [79:0] pos, neg;
	logic [3:0]  ext, lvl, pout, poe;
	int          errors, n_compared;
	fsg_regs u_dut (.clock_in, .rst_b_in, .clk_en_in, .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .trip_level_code_in(code),
		.positive_input_in(pos), .negative_input_in(neg),
		.stream_pos_status_out(spos), .stream_neg_status_out(sneg),
		.pin_in(lvl), .pin_out(pout), .pin_oe_out(poe));
	fsg_pin_model u_pins (.drive_in(pout), .oe_in(poe), .ext_in(ext),
		.level_out(lvl));
	task automatic summarize;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock_in);
		#1 wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(posedge clock_in);
		#1 wr = 0;
		rd = 0;
	endtask : acc
	// Pin levels expected from direction, written data and outside level
	task automatic pin_case(input logic [7:0] d, input logic [3:0] e);
		ext = e;
		acc(1, 5'h14, d);
		chk({4'h0, poe}, {4'h0, ~d[3:0]});
		chk({4'h0, pout & ~d[3:0]}, {4'h0, d[7:4] & ~d[3:0]});
		repeat (3) @(posedge clock_in);
		acc(0, 5'h14, 8'h00);
		chk(rdata, {(d[7:4] & ~d[3:0]) | (e & d[3:0]), d[3:0]});
	endtask : pin_case
	task automatic t_faults;
		logic [9:0] hi;
		for (int c = 0; c < 8; c++) begin
			hi = c < 5 ? 10'h3b6 - 10'h19 * c : 10'h41a - 10'h32 * c;
			code = c[2:0];
			pos = {8{10'h1f4}};
			neg = {8{10'h1f4}};
			pos[9:0] = hi + 10'h1;
			pos[19:10] = hi;
			pos[79:70] = hi + 10'h1;
			neg[29:20] = 10'h3e7 - hi;
			neg[39:30] = 10'h3e8 - hi;
			repeat (3) @(posedge clock_in);
			#1 chk(spos, 8'h81);
			chk(sneg, 8'h04);
			acc(0, 5'h12, 8'h00);
			chk(rdata & sense_en, 8'h81 & sense_en);
			acc(0, 5'h13, 8'h00);
			chk(rdata & sense_en, 8'h04 & sense_en);
		end
	endtask : t_faults
	task automatic t_misc;
		acc(0, 5'h00, 8'h00);
		chk(rdata, 8'h00);
		acc(1, 5'h12, 8'hff);
		acc(0, 5'h12, 8'h00);
		chk(rdata, 8'h81);
		clk_en_in = 0;
		pos = {8{10'h1f4}};
		acc(1, 5'h14, 8'hf0);
		chk({spos, poe}, {8'h81, 4'h5});
		clk_en_in = 1;
	endtask : t_misc
	initial begin
		clock_in = 0;
		forever #5 clock_in = ~clock_in;
	end
	// Backstop against a hang
	initial begin
		repeat (5000) @(posedge clock_in);
		errors++;
		summarize;
	end
	initial begin
		{rst_b_in, wr, rd, addr, wdata, code, ext, errors, n_compared} = '0;
		clk_en_in = 1;
		pos = {8{10'h1f4}};
		neg = pos;
		sense_en = 8'hff;
		repeat (2) @(posedge clock_in);
		#1 rst_b_in = 1;
		acc(0, 5'h14, 8'h00);
		chk(rdata, 8'h0f);
		pin_case(8'h50, 4'hf);
		pin_case(8'ha5, 4'h5);
		pin_case(8'h5a, 4'ha);
		t_faults;
		t_misc;
		summarize;
	end
endmodule : fsg_regs_tb_top
